// File: design/tws_defines.svh
// Summary of operation
// [R1] Respond only when received 7-bit address equals upper seven own-address bits.
// [R2] Own-address LSB set also answers general call 0x00; clear ignores it.
// [R3] Software writes control 0100010x before slave use: enable, acknowledge, no start/stop.
// [R4] Matched address with read bit enters transmit mode, otherwise receive mode; code returns to idle after the flag write instead.
// [R5] After own address and direction acknowledged, set event flag and post status.
// [R6] Lost arbitration then addressed for read enters transmit mode with status 0xB0.
// [R7] Final byte: load data, write flag one, acknowledge enable cleared; expect NACK.
// [R8] More bytes: load data, write flag one, acknowledge enable set; expect ACK.
// [R9] Byte sent and ACK received posts 0xB8 and waits for next byte.
// [R10] Byte sent and NACK received posts 0xC0, then not-addressed mode on release.
// [R11] Acknowledge cleared mid-transfer: send last byte, then post 0xC0 or 0xC8; code marks the final byte only from the acknowledge bit written with the flag.
// [R12] ACK after the byte marked final posts 0xC8.
// [R13] After the final byte, stop driving data; master reads all ones.
// [R14] Leaving goes not-addressed; acknowledge enable decides own address recognition.
// [R15] With acknowledge enable set, general call recognised only if its enable is one.
// [R16] Start request set on leaving makes a START once the bus is free.
// [R17] Acknowledge enable zero ignores own address, keeps monitoring, resumes when set.
// [R18] Deep sleep with acknowledge set: match address, wake, hold SCL till flag cleared.
// [R19] After deep-sleep wake the data register need not hold the bus byte.
// [R20] Software masks status prescaler bits to zero before comparing status codes.
// [R21] Flag set in an addressed transfer stretches SCL low until software writes one.
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TWS_OFF_ADDR 8'h00
`define TWS_OFF_CTRL 8'h04
`define TWS_OFF_STAT 8'h08
`define TWS_OFF_DATA 8'h0c

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define TWS_CTRL_FLAG 7
`define TWS_CTRL_ACK 6
`define TWS_CTRL_STA 5
`define TWS_CTRL_STO 4
`define TWS_CTRL_EN 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define TWS_RST_ADDR 8'h00
`define TWS_RST_CTRL 8'h00
`define TWS_RST_DATA 8'hff
`define TWS_RST_PRESC 2'h0

// ----------------------------------------
// Status codes, prescaler bits zero
// ----------------------------------------
`define TWS_ST_NOINFO 8'hf8
`define TWS_ST_SLA_R 8'ha8
`define TWS_ST_ARB_R 8'hb0
`define TWS_ST_TX_ACK 8'hb8
`define TWS_ST_TX_NACK 8'hc0
`define TWS_ST_LAST_ACK 8'hc8
`define TWS_ST_SLA_W 8'h60
`define TWS_ST_ARB_W 8'h68
`define TWS_ST_GC 8'h70
`define TWS_ST_ARB_GC 8'h78
`define TWS_GC_ADDR 7'h00
`define TWS_BITS_BYTE 4'h8

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define TWS_RESP_OKAY 2'b00
`define TWS_RESP_SLVERR 2'b10

`endif

// File: design/tws_line_if.sv
`timescale 1ns/1ps
interface tws_line_if;
  logic sclHigh;
  logic sdaHigh;
  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic busBusy;

  modport src (
    output sclHigh, sdaHigh, sclRise, sclFall, startSeen, stopSeen, busBusy
  );
  modport snk (
    input sclHigh, sdaHigh, sclRise, sclFall, startSeen, stopSeen, busBusy
  );
endinterface

// File: design/tws_line_sync.sv
`timescale 1ns/1ps
module tws_line_sync (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  tws_line_if.src ln
);
  logic [1:0] sclMeta;
  logic [1:0] sdaMeta;
  logic sclPrev;
  logic sdaPrev;
  logic busy;

  // ----------------------------------------
  // Two-stage synchronisers
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclMeta <= 2'h3;
      sdaMeta <= 2'h3;
    end else begin
      sclMeta <= {sclMeta[0], sclIn};
      sdaMeta <= {sdaMeta[0], sdaIn};
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclMeta[1];
      sdaPrev <= sdaMeta[1];
    end
  end

  // ----------------------------------------
  // Edge and condition detection
  // ----------------------------------------
  assign ln.sclHigh = sclMeta[1];
  assign ln.sdaHigh = sdaMeta[1];
  assign ln.sclRise = sclMeta[1] & ~sclPrev;
  assign ln.sclFall = ~sclMeta[1] & sclPrev;
  assign ln.startSeen = sclMeta[1] & sclPrev & sdaPrev & ~sdaMeta[1];
  assign ln.stopSeen = sclMeta[1] & sclPrev & ~sdaPrev & sdaMeta[1];
  assign ln.busBusy = busy;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else if (ln.startSeen) begin
      busy <= 1'b1;
    end else if (ln.stopSeen) begin
      busy <= 1'b0;
    end
  end
endmodule

// File: design/tws_pkg.sv
package tws_pkg;

  typedef enum logic [2:0] {
    TWS_IDLE,
    TWS_ADDR,
    TWS_ADDR_ACK,
    TWS_WAIT,
    TWS_TX,
    TWS_TX_ACK,
    TWS_END
  } tws_state_e;

endpackage

// File: design/tws_slave_tx.sv
`timescale 1ns/1ps
`include "tws_defines.svh"
module tws_slave_tx #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic sclIn,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic sleepDeep,
  input wire logic arbLostAddr,
  output logic wakeRequest,
  output logic startGo,
  output logic slaveActive
);
  import tws_pkg::*;

  initial begin
    if (AW < 8) begin
      $error("tws_slave_tx: AW must be at least 8");
    end
  end

  tws_line_if ln ();

  tws_line_sync u_sync (
    .ref_clk(ref_clk),
    .arst_n(arst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .ln(ln)
  );

  tws_pkg::tws_state_e state;
  logic [7:0] ownAddr;
  logic ackEnable;
  logic startReq;
  logic stopReq;
  logic ifEnable;
  logic eventFlag;
  logic [7:0] statusCode;
  logic [1:0] prescaler;
  logic [7:0] dataReg;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic [3:0] bitCnt;
  logic readMode;
  logic lastByte;
  logic ackSeen;
  logic gotRise;
  logic startPending;
  logic matchOwn;
  logic matchGc;
  logic addrHit;
  logic wrFire;
  logic wrLane;
  logic [7:0] wrByte;
  logic ctrlWrite;
  logic swGo;
  logic flagSet;
  logic leaving;
  logic [7:0] next_status;
  logic [AW-1:0] rdAddr;
  localparam logic [7:0] CTRL_RST = `TWS_RST_CTRL;

  // ----------------------------------------
  // Register write channel
  // ----------------------------------------
  assign wrFire = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wrFire;
  assign s_axi_wready = wrFire;
  assign wrLane = wrFire & s_axi_wstrb[0];
  assign wrByte = s_axi_wdata[7:0];
  assign ctrlWrite = wrLane && (s_axi_awaddr[7:0] == `TWS_OFF_CTRL);
  // Writing one to the flag releases the waiting transfer
  assign swGo = ctrlWrite & wrByte[`TWS_CTRL_FLAG] & eventFlag; // see [R21]

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TWS_RESP_OKAY;
    end else if (wrFire) begin
      s_axi_bvalid <= 1'b1;
      unique case (s_axi_awaddr[7:0])
        `TWS_OFF_ADDR, `TWS_OFF_CTRL, `TWS_OFF_STAT, `TWS_OFF_DATA: begin
          s_axi_bresp <= `TWS_RESP_OKAY;
        end
        default: begin
          s_axi_bresp <= `TWS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ownAddr <= `TWS_RST_ADDR;
    end else if (wrLane && (s_axi_awaddr[7:0] == `TWS_OFF_ADDR)) begin
      ownAddr <= wrByte;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackEnable <= CTRL_RST[`TWS_CTRL_ACK];
      startReq <= CTRL_RST[`TWS_CTRL_STA];
      stopReq <= CTRL_RST[`TWS_CTRL_STO];
      ifEnable <= CTRL_RST[`TWS_CTRL_EN];
    end else if (ctrlWrite) begin
      // Acknowledge enable may change at any time
      ackEnable <= wrByte[`TWS_CTRL_ACK]; // see [R17]
      startReq <= wrByte[`TWS_CTRL_STA];
      stopReq <= wrByte[`TWS_CTRL_STO];
      ifEnable <= wrByte[`TWS_CTRL_EN];
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prescaler <= `TWS_RST_PRESC;
    end else if (wrLane && (s_axi_awaddr[7:0] == `TWS_OFF_STAT)) begin
      prescaler <= wrByte[1:0];
    end
  end

  // ----------------------------------------
  // Register read channel
  // ----------------------------------------
  assign s_axi_arready = ~s_axi_rvalid;
  assign rdAddr = s_axi_araddr;

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `TWS_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `TWS_RESP_OKAY;
      unique case (rdAddr[7:0])
        `TWS_OFF_ADDR: s_axi_rdata <= {24'h0, ownAddr};
        `TWS_OFF_CTRL: begin
          s_axi_rdata <= {24'h0, eventFlag, ackEnable, startReq, stopReq,
                          1'b0, ifEnable, 2'h0};
        end
        // Prescaler bits share the low end of the status byte
        `TWS_OFF_STAT: begin
          s_axi_rdata <= {24'h0, statusCode[7:3], 1'b0, prescaler}; // see [R20]
        end
        `TWS_OFF_DATA: s_axi_rdata <= {24'h0, dataReg};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= `TWS_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Address recognition
  // ----------------------------------------
  // Enable pattern from software gates all recognition
  assign matchOwn = rxShift[7:1] == ownAddr[7:1]; // see [R1] [R3]
  assign matchGc = ownAddr[0] && (rxShift[7:1] == `TWS_GC_ADDR); // see [R2] [R15]
  // Acknowledge enable off isolates the unit, in sleep too
  assign addrHit = ifEnable & ackEnable & (matchOwn | matchGc); // see [R14] [R17] [R18]

  always_comb begin
    next_status = `TWS_ST_NOINFO;
    if (state == TWS_ADDR_ACK) begin
      if (readMode) begin
        next_status = arbLostAddr ? `TWS_ST_ARB_R : `TWS_ST_SLA_R; // see [R6]
      end else if (rxShift[7:1] == `TWS_GC_ADDR) begin
        next_status = arbLostAddr ? `TWS_ST_ARB_GC : `TWS_ST_GC;
      end else begin
        next_status = arbLostAddr ? `TWS_ST_ARB_W : `TWS_ST_SLA_W;
      end
    end else if (!ackSeen) begin
      next_status = `TWS_ST_TX_NACK; // see [R10] [R11]
    end else if (lastByte) begin
      next_status = `TWS_ST_LAST_ACK; // see [R11] [R12]
    end else begin
      next_status = `TWS_ST_TX_ACK; // see [R9]
    end
  end

  assign flagSet = ln.sclFall && ((state == TWS_ADDR_ACK) ||
                   ((state == TWS_TX_ACK) && gotRise));
  assign leaving = swGo && (state == TWS_END);

  // ----------------------------------------
  // Transfer sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= TWS_IDLE;
      bitCnt <= 4'h0;
      rxShift <= 8'h0;
      txShift <= 8'hff;
      readMode <= 1'b0;
      lastByte <= 1'b0;
      ackSeen <= 1'b0;
      gotRise <= 1'b0;
    end else if (!ifEnable) begin
      state <= TWS_IDLE;
    end else if (ln.startSeen && state != TWS_WAIT && state != TWS_END) begin
      state <= TWS_ADDR;
      bitCnt <= 4'h0;
    end else if (ln.stopSeen && state != TWS_WAIT && state != TWS_END) begin
      state <= TWS_IDLE;
    end else begin
      unique case (state)
        TWS_IDLE: begin
          bitCnt <= 4'h0;
        end
        TWS_ADDR: begin
          if (ln.sclRise && bitCnt < `TWS_BITS_BYTE) begin
            rxShift <= {rxShift[6:0], ln.sdaHigh};
            bitCnt <= bitCnt + 4'h1;
          end else if (ln.sclFall && bitCnt == `TWS_BITS_BYTE) begin
            // Direction bit selects transmit, or idle once the flag is written
            readMode <= rxShift[0]; // see [R4]
            state <= addrHit ? TWS_ADDR_ACK : TWS_IDLE;
          end
        end
        TWS_ADDR_ACK: begin
          if (ln.sclFall) begin
            state <= TWS_WAIT; // see [R5]
          end
        end
        TWS_WAIT: begin
          if (swGo && readMode) begin
            // Acknowledge enable written now marks the byte as final
            lastByte <= ~wrByte[`TWS_CTRL_ACK]; // see [R7] [R8]
            txShift <= dataReg;
            bitCnt <= 4'h0;
            state <= TWS_TX;
          end else if (swGo) begin
            state <= TWS_IDLE;
          end
        end
        TWS_TX: begin
          if (ln.sclFall) begin
            txShift <= {txShift[6:0], 1'b1};
            bitCnt <= bitCnt + 4'h1;
            gotRise <= 1'b0;
            if (bitCnt == `TWS_BITS_BYTE - 4'h1) begin
              state <= TWS_TX_ACK;
            end
          end
        end
        TWS_TX_ACK: begin
          if (ln.sclRise) begin
            ackSeen <= ~ln.sdaHigh;
            gotRise <= 1'b1;
          end else if (ln.sclFall && gotRise) begin
            // Final byte never continues, whatever the master answers
            state <= (ackSeen && !lastByte) ? TWS_WAIT : TWS_END; // see [R13]
          end
        end
        TWS_END: begin
          if (swGo) begin
            state <= TWS_IDLE; // see [R10] [R14]
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Event flag and status
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      eventFlag <= 1'b0;
    end else if (flagSet && ifEnable) begin
      eventFlag <= 1'b1;
    end else if (swGo) begin
      eventFlag <= 1'b0; // see [R18] [R21]
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      statusCode <= `TWS_ST_NOINFO;
    end else if (flagSet && ifEnable) begin
      statusCode <= next_status;
    end else if (swGo) begin
      statusCode <= `TWS_ST_NOINFO;
    end
  end

  // Received address copied only while awake
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      dataReg <= `TWS_RST_DATA;
    end else if (wrLane && (s_axi_awaddr[7:0] == `TWS_OFF_DATA)) begin
      dataReg <= wrByte;
    end else if (flagSet && state == TWS_ADDR_ACK && !sleepDeep) begin
      dataReg <= rxShift; // see [R19]
    end
  end

  // ----------------------------------------
  // Start after leaving
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      startPending <= 1'b0;
    end else if (leaving && wrByte[`TWS_CTRL_STA]) begin
      startPending <= 1'b1; // see [R16]
    end else if (startPending && !ln.busBusy) begin
      startPending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      startGo <= 1'b0;
    end else begin
      startGo <= startPending & ~ln.busBusy & ~startGo; // see [R16]
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  // Hold clock low while software owes an answer
  assign sclOe = eventFlag && (state == TWS_WAIT || state == TWS_END); // see [R21] [R18]
  // Released data line reads as ones once the transfer is over
  assign sdaOe = (state == TWS_ADDR_ACK) ||
                 (state == TWS_TX && !txShift[7]); // see [R13]
  assign wakeRequest = sleepDeep & eventFlag; // see [R18]
  assign slaveActive = (state != TWS_IDLE) && (state != TWS_ADDR);
endmodule

// File: sim/tb_tws_slave_tx.sv
`timescale 1ns/1ps
module tb_tws_slave_tx;
  logic ref_clk, arst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, sclIn, sclOut, sclOe;
  logic sdaIn, sdaOut, sdaOe, sleepDeep, arbLostAddr, wakeRequest;
  logic startGo, slaveActive, mScl, mSda, ak;
  logic [7:0] s_axi_awaddr, s_axi_araddr, q;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [7:0] rv[5] = '{8'h00, 8'h00, 8'hf8, 8'hff, 8'h00};
  int errors, tests_run, starts;
  assign sclIn = ~(sclOe | mScl);
  assign sdaIn = ~(sdaOe | mSda);
  tws_slave_tx i_tws_slave_tx (.*);
  tws_i2c_master i_tws_i2c_master (
    .scl(sclIn),
    .sda(sdaIn),
    .sclLow(mScl),
    .sdaLow(mSda)
  );
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (startGo === 1'b1) starts <= starts + 1;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v,
                    input logic [1:0] er = 2'b00);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    input logic [1:0] er = 2'b00);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  // Polls the event flag, then checks status with prescaler masked
  task automatic flag(input logic [7:0] e);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 400 && v[7] !== 1'b1; i++) rd(8'h04, v);
    rd(8'h08, v);
    chk("status", {24'h0, e}, v & 32'hf8);
  endtask
  task automatic adr(input logic [7:0] b, input logic ea,
                     input logic [7:0] st);
    fork
      begin
        i_tws_i2c_master.start();
        i_tws_i2c_master.xfer(1'b1, b, 1'b0, q, ak);
        chk("addrAck", {31'h0, ea}, {31'h0, ak});
        i_tws_i2c_master.stop();
      end
      if (ea) begin
        flag(st);
        wr(8'h04, 8'hc4);
      end
    join
  endtask
  task automatic final_report();
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    final_report();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    {arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 4'h0;
    {sleepDeep, arbLostAddr, s_axi_awaddr, s_axi_araddr} = 18'h0;
    {s_axi_bready, s_axi_rready, s_axi_wdata, s_axi_wstrb} = 38'h3_0000_0000_1;
    {errors, tests_run, starts} = '0;
    repeat (3) @(posedge ref_clk);
    arst_n <= 1'b1;
    foreach (ra[i]) begin
      rd(ra[i], d, i == 4 ? 2'b10 : 2'b00);
      chk("resetValue", {24'h0, rv[i]}, d);
    end
    wr(8'h10, 8'h11, 2'b10);
    wr(8'h08, 8'h03);
    rd(8'h08, d);
    chk("prescaler", 32'hfb, d);
    wr(8'h08, 8'h00);
    wr(8'h00, 8'h55);
    wr(8'h04, 8'h44);
    sleepDeep <= 1'b1;
    fork
      begin
        i_tws_i2c_master.start();
        i_tws_i2c_master.xfer(1'b1, 8'h55, 1'b0, q, ak);
        chk("readAddrAck", 1, {31'h0, ak});
        i_tws_i2c_master.xfer(1'b0, 8'h00, 1'b1, q, ak);
        chk("byte0", 8'ha5, q);
        i_tws_i2c_master.xfer(1'b0, 8'h00, 1'b1, q, ak);
        chk("byte1", 8'h3c, q);
        i_tws_i2c_master.xfer(1'b0, 8'h00, 1'b0, q, ak);
        chk("afterLast", 8'hff, q);
        i_tws_i2c_master.stop();
      end
      begin
        flag(8'ha8);
        chk("wake", 1, {31'h0, wakeRequest});
        wr(8'h0c, 8'ha5);
        wr(8'h04, 8'hc4);
        flag(8'hb8);
        wr(8'h0c, 8'h3c);
        wr(8'h04, 8'h84);
        flag(8'hc8);
        wr(8'h04, 8'hc4);
      end
    join
    @(posedge ref_clk);
    sleepDeep <= 1'b0;
    arbLostAddr <= 1'b1;
    fork
      begin
        i_tws_i2c_master.start();
        i_tws_i2c_master.xfer(1'b1, 8'h55, 1'b0, q, ak);
        i_tws_i2c_master.xfer(1'b0, 8'h00, 1'b0, q, ak);
        chk("lastByte", 8'h81, q);
        i_tws_i2c_master.stop();
      end
      begin
        flag(8'hb0);
        wr(8'h0c, 8'h81);
        wr(8'h04, 8'h84);
        flag(8'hc0);
        wr(8'h04, 8'he4);
      end
    join
    repeat (20) @(posedge ref_clk);
    chk("startPulses", 1, starts);
    arbLostAddr <= 1'b0;
    adr(8'h61, 1'b0, 8'h00);
    adr(8'h00, 1'b1, 8'h70);
    wr(8'h00, 8'h54);
    adr(8'h00, 1'b0, 8'h00);
    wr(8'h04, 8'h04);
    adr(8'h54, 1'b0, 8'h00);
    wr(8'h04, 8'h44);
    adr(8'h54, 1'b1, 8'h60);
    final_report();
  end
endmodule

// File: sim/tws_i2c_master.sv
`timescale 1ns/1ps
module tws_i2c_master (
  input wire logic scl,
  input wire logic sda,
  output logic sclLow,
  output logic sdaLow
);
  initial begin
    sclLow = 1'b0;
    sdaLow = 1'b0;
  end
  // One bit; waits out any stretch
  task automatic bit_slot(input logic b, output logic s);
    sdaLow = ~b;
    #20;
    sclLow = 1'b0;
    wait (scl === 1'b1);
    #20;
    s = sda;
    #20;
    sclLow = 1'b1;
    #20;
  endtask
  task automatic start();
    sdaLow = 1'b1;
    #40;
    sclLow = 1'b1;
    #20;
  endtask
  task automatic stop();
    sdaLow = 1'b1;
    #20;
    sclLow = 1'b0;
    wait (scl === 1'b1);
    #40;
    sdaLow = 1'b0;
    #40;
  endtask
  // Sends d when wr, else reads into q and answers ackIt
  task automatic xfer(input logic wr, input logic [7:0] d,
                      input logic ackIt, output logic [7:0] q,
                      output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(wr ? d[i] : 1'b1, s);
      q[i] = s;
    end
    bit_slot(wr ? 1'b1 : ~ackIt, s);
    ack = ~s;
  endtask
endmodule

// File: sim/tws_slave_tx_asserts.sv
`timescale 1ns/1ps
module tws_slave_tx_asserts #(
  parameter int AW = 8
) (
  input wire logic ref_clk,
  input wire logic arst_n,
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic sclOe,
  input wire logic sdaOe,
  input wire logic sleepDeep,
  input wire logic wakeRequest,
  input wire logic startGo,
  input wire logic slaveActive
);
  logic ackEn;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ----------------------------------------
  // Shadow of acknowledge enable
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackEn <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                 s_axi_awaddr[7:0] == 8'h04 && s_axi_wstrb[0]) begin
      ackEn <= s_axi_wdata[6];
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid;
  endsequence
  sequence s_flagw;
    s_wtake ##0 (s_axi_awaddr[7:0] == 8'h04 && s_axi_wdata[7] &&
                 s_axi_wstrb[0]);
  endsequence
  property p_bans; s_wtake |=> s_axi_bvalid; endproperty
  a_bans: assert property (p_bans)
    else $error("write answer late");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans)
    else $error("read answer late");
  property p_unmap;
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:0] > 8'h0c |=>
      s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not refused");
  property p_wake; $rose(wakeRequest) |-> sleepDeep ##[0:4] sclOe; endproperty
  a_wake: assert property (p_wake)
    else $error("wake without sleep or stretch");
  property p_stretch; $rose(sclOe) |-> slaveActive; endproperty
  a_stretch: assert property (p_stretch)
    else $error("stretch while not addressed");
  property p_release; s_flagw |-> ##[1:2] !sclOe; endproperty
  a_release: assert property (p_release)
    else $error("stretch not released");
  property p_startgo; startGo |-> !slaveActive ##1 !startGo; endproperty
  a_startgo: assert property (p_startgo)
    else $error("start pulse wrong");
  property p_quiet; !ackEn && !slaveActive |-> !sdaOe; endproperty
  a_quiet: assert property (p_quiet)
    else $error("drives data while isolated");
endmodule

bind tws_slave_tx tws_slave_tx_asserts #(.AW(AW)) i_tws_slave_tx_asserts (.*);
